// >>> dv/tb_top.sv
// Self-checking testbench for the output divider configuration page
`include "odcp_defs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import odcp_pkg::*;

    // ------------------------------------------------------------------------
    // Signals and design instance
    // ------------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n;
    logic ce;
    odcp_byte_t cfg_addr;
    logic cfg_wr;
    odcp_byte_t cfg_wdata;
    logic cfg_rd;
    odcp_byte_t cfg_rdata;
    logic true_pad_drive;
    logic comp_pad_drive;
    logic [2:0] fine_step;
    logic [2:0] drive_strength;
    logic [2:0] supply_level_code;
    logic [5:0] driver_standard_select;
    logic true_cmos_en;
    logic comp_cmos_en;
    logic diff_en;
    logic pullup_en;
    logic pulldown_en;
    int n_mismatch;
    int checks;
    int cyc = 0;

    odcp_output_page dut_u (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .cfg_addr(cfg_addr),
        .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata),
        .cfg_rd(cfg_rd),
        .cfg_rdata(cfg_rdata),
        .true_pad_drive(true_pad_drive),
        .comp_pad_drive(comp_pad_drive),
        .fine_step(fine_step),
        .drive_strength(drive_strength),
        .supply_level_code(supply_level_code),
        .driver_standard_select(driver_standard_select),
        .true_cmos_en(true_cmos_en),
        .comp_cmos_en(comp_cmos_en),
        .diff_en(diff_en),
        .pullup_en(pullup_en),
        .pulldown_en(pulldown_en)
    );

    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
    end

    // ------------------------------------------------------------------------
    // Access and compare tasks; all are entered just after a falling edge
    // ------------------------------------------------------------------------
    task automatic results;
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A strobe stays up until the next access or idle, so back-to-back
    // calls never lower and raise it in the same time step
    task automatic wr(input odcp_byte_t a, input odcp_byte_t d);
        cfg_rd = 1'b0;
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge clk);
    endtask

    task automatic rchk(input odcp_byte_t a, input odcp_byte_t exp);
        cfg_wr = 1'b0;
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge clk);
        chk(cfg_rdata, exp);
    endtask

    task automatic idle(input int cycles);
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        repeat (cycles) @(negedge clk);
    endtask

    // Decoded outputs trail a write by two edges
    task automatic settle;
        idle(3);
    endtask

    function automatic logic pad(input int sel);
        return (sel == 0) ? true_pad_drive : comp_pad_drive;
    endfunction

    task automatic wait_lvl(input int sel, input logic v);
        int k;
        k = 0;
        while (pad(sel) !== v)
        begin
            @(negedge clk);
            k++;
            if (k > 2000)
            begin
                n_mismatch++;
                results();
            end
        end
    endtask

    task automatic hi_len(input int sel, output int n);
        wait_lvl(sel, 1'b0);
        wait_lvl(sel, 1'b1);
        n = 0;
        while (pad(sel) === 1'b1 && n < 1000)
        begin
            n++;
            @(negedge clk);
        end
    endtask

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    odcp_byte_t masks[8] = '{8'h0f, 8'hff, 8'hff, 8'hc7, 8'hff, 8'hdf, 8'h00, 8'h1f};
    odcp_byte_t pads[7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h0c, 8'h03};
    logic [4:0] pad_exp[7] = '{5'h04, 5'h05, 5'h06, 5'h10, 5'h08, 5'h18, 5'h00};
    int n;
    int t0;
    int t1;

    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        cfg_addr = 8'h00;
        cfg_wr = 1'b0;
        cfg_wdata = 8'h00;
        cfg_rd = 1'b0;
        n_mismatch = 0;
        checks = 0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        // Stopped clock: the complement pad idles high under phase code 00
        chk({true_pad_drive, comp_pad_drive, fine_step, drive_strength}, 32'h40);
        settle();
        chk(diff_en, 32'h1);
        for (int i = 0; i < 8; i++)
            rchk(8'h50 + 8'(i), 8'h00);
        // Undefined bits must drop; 56h is unmapped and must read zero
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h50 + 8'(i), 8'hff);
            rchk(8'h50 + 8'(i), masks[i]);
            wr(8'h50 + 8'(i), 8'h00);
        end
        wr(`ODCP_ADDR_SUPPLY, 8'hc0);
        rchk(`ODCP_ADDR_SUPPLY, 8'hc0);
        ce = 1'b0;
        wr(`ODCP_ADDR_DIV_LOW, 8'h5a);
        ce = 1'b1;
        rchk(`ODCP_ADDR_DIV_LOW, 8'h00);
        wr(`ODCP_ADDR_PHASE, 8'h07);
        settle();
        chk(drive_strength, 32'h7);
        for (int i = 0; i < 8; i++)
        begin
            wr(`ODCP_ADDR_SUPPLY, {3'h0, 2'(i), 3'(i)});
            settle();
            chk(supply_level_code, (i % 4 < 3) ? (32'h1 << (i % 4)) : 32'h0);
            chk(driver_standard_select, (i < 6) ? (32'h1 << i) : 32'h0);
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(`ODCP_ADDR_DELAY, {2'(i), 6'h00});
            wr(`ODCP_ADDR_PAD, {3'h0, i[2], 4'h0});
            settle();
            chk(fine_step, (i > 4) ? 32'h4 : 32'(i));
        end
        for (int i = 0; i < 7; i++)
        begin
            wr(`ODCP_ADDR_PAD, pads[i]);
            settle();
            chk({true_cmos_en, comp_cmos_en, diff_en, pullup_en, pulldown_en},
                pad_exp[i]);
        end
        // Odd ratio makes the two phases tell apart: high 2, low 3
        wr(`ODCP_ADDR_DIV_LOW, 8'h05);
        for (int ph = 0; ph < 4; ph++)
        begin
            wr(`ODCP_ADDR_PHASE, {2'(ph), 6'h07});
            idle(20);
            hi_len(0, n);
            chk(n, (ph >= 2) ? 32'd3 : 32'd2);
            hi_len(1, n);
            chk(n, (ph % 2 == 1) ? 32'd2 : 32'd3);
        end
        wr(`ODCP_ADDR_PHASE, 8'h00);
        wr(`ODCP_ADDR_DIV_MID, 8'h01);
        wr(`ODCP_ADDR_DIV_LOW, 8'h02);
        // Skip the first pulse after a ratio change, which may be cut short
        idle(10);
        hi_len(0, n);
        chk(n, 32'd129);
        wr(`ODCP_ADDR_DIV_MID, 8'h00);
        wr(`ODCP_ADDR_DIV_LOW, 8'h04);
        idle(10);
        hi_len(0, n);
        chk(n, 32'd2);
        wr(`ODCP_ADDR_DIV_LOW, 8'h01);
        idle(300);
        n = 0;
        for (int i = 0; i < 20; i++)
        begin
            if (true_pad_drive !== 1'b0)
                n++;
            @(negedge clk);
        end
        chk(n, 32'd0);
        // Counter keeps running across delay writes, so the rise shifts by the delay
        wr(`ODCP_ADDR_DIV_LOW, 8'h64);
        idle(120);
        wait_lvl(0, 1'b0);
        wait_lvl(0, 1'b1);
        t0 = cyc;
        for (int c = 1; c < 64; c += 31)
        begin
            wr(`ODCP_ADDR_DELAY, 8'(c));
            idle(80);
            wait_lvl(0, 1'b0);
            wait_lvl(0, 1'b1);
            t1 = cyc;
            chk((t1 - t0) % 100, c);
        end
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        rchk(`ODCP_ADDR_DELAY, 8'h00);
        results();
    end
endmodule // tb_top

// >>> rtl/odcp_coarse_delay.sv
// Coarse delay line: delays the divided clock by a programmable number of cycles
`include "odcp_defs.svh"

module odcp_coarse_delay (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_i,
    input wire odcp_pkg::odcp_coarse_t coarse_i,
    output logic out_o
);
    import odcp_pkg::*;

    odcp_dly_s s_q;
    odcp_dly_s s_d;
    logic [`ODCP_COARSE_TAPS-1:0] taps;

    // ------------------------------------------------------------------------
    // Tap vector: tap 0 is the live input, tap n is n stages back
    // ------------------------------------------------------------------------
    assign taps[0] = in_i;
    for (genvar i = 1; i < `ODCP_COARSE_TAPS; i++)
    begin : g_tap
        assign taps[i] = s_q.line[i-1];
    end

    always_comb
    begin
        s_d = s_q;
        if (ce)
        begin
            s_d.line = {s_q.line[61:0], in_i};
            s_d.out = taps[coarse_i];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign out_o = s_q.out;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_coarse_one: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && coarse_i == 6'h01) [*3] |-> out_o == $past(in_i, 2))
        else $error("coarse delay of one stage not two cycles");

    a_coarse_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && coarse_i == 6'h00) [*2] |-> out_o == $past(in_i, 1))
        else $error("coarse delay of zero not one cycle");
endmodule // odcp_coarse_delay

// >>> rtl/odcp_defs.svh
// Offsets, field positions, codes and reset values of the output divider page
`ifndef ODCP_DEFS_SVH
`define ODCP_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ODCP_ADDR_DIV_HIGH 8'h50
`define ODCP_ADDR_DIV_MID 8'h51
`define ODCP_ADDR_DIV_LOW 8'h52
`define ODCP_ADDR_PHASE 8'h53
`define ODCP_ADDR_DELAY 8'h54
`define ODCP_ADDR_SUPPLY 8'h55
`define ODCP_ADDR_PAD 8'h57

// ----------------------------------------------------------------------------
// Writable bits per register and reset value
// ----------------------------------------------------------------------------
`define ODCP_MASK_DIV_HIGH 8'h0f
`define ODCP_MASK_FULL 8'hff
`define ODCP_MASK_PHASE 8'hc7
`define ODCP_MASK_SUPPLY 8'hdf
`define ODCP_MASK_PAD 8'h1f
`define ODCP_RESET_BYTE 8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ODCP_DIV_HIGH_F 3:0
`define ODCP_DIV_TOP_F 7:6
`define ODCP_PHASE_F 7:6
`define ODCP_STRENGTH_F 2:0
`define ODCP_COARSE_F 5:0
`define ODCP_FINE_F 7:6
`define ODCP_FINE_EXT_BIT 4
`define ODCP_SUPPLY_F 4:3
`define ODCP_DRIVER_F 2:0
`define ODCP_PAD_F 3:0

// ----------------------------------------------------------------------------
// Codes and counts
// ----------------------------------------------------------------------------
`define ODCP_SUPPLY_1V8 2'h0
`define ODCP_SUPPLY_2V5 2'h1
`define ODCP_SUPPLY_3V3 2'h2
`define ODCP_DRV_LVDS 3'h0
`define ODCP_DRV_LVPECL_CM 3'h1
`define ODCP_DRV_CML 3'h2
`define ODCP_DRV_HCSL 3'h3
`define ODCP_DRV_LVDS_BOOST 3'h4
`define ODCP_DRV_LVPECL_NOCM 3'h5
`define ODCP_PAD_DIFF_EXT 4'h0
`define ODCP_PAD_DIFF_PULLDN 4'h1
`define ODCP_PAD_DIFF_PULLUP 4'h2
`define ODCP_PAD_CMOS_TRUE 4'h4
`define ODCP_PAD_CMOS_COMP 4'h8
`define ODCP_PAD_CMOS_BOTH 4'hc
`define ODCP_FINE_MAX 3'h4
`define ODCP_RATIO_MIN 30'h0000_0002
`define ODCP_COARSE_TAPS 64

`endif

// >>> rtl/odcp_output_page.sv
// Configuration page and clock path of one divided, delayed clock output
//
// Summary of operation
// - Divider bits 19:0 from 50h, 51h, 52h
// - 55h bits 7:6 are divider bits 29:28
// - 53h bits 7:6 route phases to pads
// - Coarse delay 0 to 63 clock periods
// - Fine delay zero to three 30 ps steps
// - 57h bit 4 extends fine delay to four
// - 55h bits 4:3 select supply level
// - 55h bits 2:0 select driver standard
// - Pad codes 1000 and 1100 select CMOS
// - Pad code 0000 is externally terminated differential
// - Codes 0010, 0001, 0100: pull-up, pull-down, CMOS
`include "odcp_defs.svh"

module odcp_output_page (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire odcp_pkg::odcp_byte_t cfg_addr,
    input wire logic cfg_wr,
    input wire odcp_pkg::odcp_byte_t cfg_wdata,
    input wire logic cfg_rd,
    output odcp_pkg::odcp_byte_t cfg_rdata,
    output logic true_pad_drive,
    output logic comp_pad_drive,
    output logic [2:0] fine_step,
    output logic [2:0] drive_strength,
    output logic [2:0] supply_level_code,
    output logic [5:0] driver_standard_select,
    output logic true_cmos_en,
    output logic comp_cmos_en,
    output logic diff_en,
    output logic pullup_en,
    output logic pulldown_en
);
    import odcp_pkg::*;

    odcp_state_s s_q;
    odcp_state_s s_d;
    odcp_ratio_t output_divide_ratio;
    odcp_ratio_t half_ratio;
    odcp_ratio_t cnt_next;
    logic delayed_clk;
    logic clock_true_phase;
    logic clock_comp_phase;
    logic [2:0] fine_code;
    logic [1:0] phase_sel;

    // ------------------------------------------------------------------------
    // Divider value assembly; bits 27:20 have no register on this page
    // ------------------------------------------------------------------------
    assign output_divide_ratio = {s_q.supply_ctl[`ODCP_DIV_TOP_F], 8'h00,
                                  s_q.div_high[`ODCP_DIV_HIGH_F],
                                  s_q.div_mid, s_q.div_low};
    assign half_ratio = output_divide_ratio >> 1;
    assign fine_code = {s_q.pad_ctl[`ODCP_FINE_EXT_BIT], s_q.delay_ctl[`ODCP_FINE_F]};
    assign phase_sel = s_q.phase_ctl[`ODCP_PHASE_F];

    // ------------------------------------------------------------------------
    // Coarse delay of the divided clock
    // ------------------------------------------------------------------------
    odcp_coarse_delay u_coarse (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_i(s_q.div_clk),
        .coarse_i(s_q.delay_ctl[`ODCP_COARSE_F]),
        .out_o(delayed_clk)
    );

    assign clock_true_phase = delayed_clk;
    assign clock_comp_phase = ~delayed_clk;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        cnt_next = s_q.cnt;
        if (ce)
        begin
            // Register writes; undefined bits are masked so they read zero
            if (cfg_wr)
            begin
                unique case (cfg_addr)
                    `ODCP_ADDR_DIV_HIGH: s_d.div_high = cfg_wdata & `ODCP_MASK_DIV_HIGH;
                    `ODCP_ADDR_DIV_MID: s_d.div_mid = cfg_wdata & `ODCP_MASK_FULL;
                    `ODCP_ADDR_DIV_LOW: s_d.div_low = cfg_wdata & `ODCP_MASK_FULL;
                    `ODCP_ADDR_PHASE: s_d.phase_ctl = cfg_wdata & `ODCP_MASK_PHASE;
                    `ODCP_ADDR_DELAY: s_d.delay_ctl = cfg_wdata & `ODCP_MASK_FULL;
                    `ODCP_ADDR_SUPPLY: s_d.supply_ctl = cfg_wdata & `ODCP_MASK_SUPPLY;
                    `ODCP_ADDR_PAD: s_d.pad_ctl = cfg_wdata & `ODCP_MASK_PAD;
                    default: ;
                endcase
            end

            // Read data is captured and held until the next read
            if (cfg_rd)
            begin
                unique case (cfg_addr)
                    `ODCP_ADDR_DIV_HIGH: s_d.rdata = s_q.div_high;
                    `ODCP_ADDR_DIV_MID: s_d.rdata = s_q.div_mid;
                    `ODCP_ADDR_DIV_LOW: s_d.rdata = s_q.div_low;
                    `ODCP_ADDR_PHASE: s_d.rdata = s_q.phase_ctl;
                    `ODCP_ADDR_DELAY: s_d.rdata = s_q.delay_ctl;
                    `ODCP_ADDR_SUPPLY: s_d.rdata = s_q.supply_ctl;
                    `ODCP_ADDR_PAD: s_d.rdata = s_q.pad_ctl;
                    default: s_d.rdata = `ODCP_RESET_BYTE;
                endcase
            end

            // Divider: ratios below two park the output low, since a
            // registered output cannot pass the clock itself through
            if (output_divide_ratio < `ODCP_RATIO_MIN)
                cnt_next = '0;
            else if (s_q.cnt >= output_divide_ratio - 30'h0000_0001)
                cnt_next = '0;
            else
                cnt_next = s_q.cnt + 30'h0000_0001;
            s_d.cnt = cnt_next;
            s_d.div_clk = (output_divide_ratio >= `ODCP_RATIO_MIN)
                          && (cnt_next < half_ratio);

            // Phase routing to the two pads
            s_d.true_pad = phase_sel[1] ? clock_comp_phase : clock_true_phase;
            s_d.comp_pad = phase_sel[0] ? clock_true_phase : clock_comp_phase;

            // Fine step for the analog delay cell; codes past four clamp
            if (fine_code > `ODCP_FINE_MAX)
                s_d.fine_step = `ODCP_FINE_MAX;
            else
                s_d.fine_step = fine_code;

            // Passed through as written; seven is the value software uses
            s_d.strength = s_q.phase_ctl[`ODCP_STRENGTH_F];

            unique case (s_q.supply_ctl[`ODCP_SUPPLY_F])
                `ODCP_SUPPLY_1V8: s_d.supply_sel = 3'h1;
                `ODCP_SUPPLY_2V5: s_d.supply_sel = 3'h2;
                `ODCP_SUPPLY_3V3: s_d.supply_sel = 3'h4;
                default: s_d.supply_sel = 3'h0;
            endcase

            unique case (s_q.supply_ctl[`ODCP_DRIVER_F])
                `ODCP_DRV_LVDS: s_d.driver_sel = 6'h01;
                `ODCP_DRV_LVPECL_CM: s_d.driver_sel = 6'h02;
                `ODCP_DRV_CML: s_d.driver_sel = 6'h04;
                `ODCP_DRV_HCSL: s_d.driver_sel = 6'h08;
                `ODCP_DRV_LVDS_BOOST: s_d.driver_sel = 6'h10;
                `ODCP_DRV_LVPECL_NOCM: s_d.driver_sel = 6'h20;
                default: s_d.driver_sel = 6'h00;
            endcase

            // Unlisted pad codes leave both pads undriven
            s_d.true_cmos = 1'b0;
            s_d.comp_cmos = 1'b0;
            s_d.diff_en = 1'b0;
            s_d.pullup_en = 1'b0;
            s_d.pulldown_en = 1'b0;
            unique case (s_q.pad_ctl[`ODCP_PAD_F])
                `ODCP_PAD_DIFF_EXT: s_d.diff_en = 1'b1;
                `ODCP_PAD_DIFF_PULLUP:
                begin
                    s_d.diff_en = 1'b1;
                    s_d.pullup_en = 1'b1;
                end
                `ODCP_PAD_DIFF_PULLDN:
                begin
                    s_d.diff_en = 1'b1;
                    s_d.pulldown_en = 1'b1;
                end
                `ODCP_PAD_CMOS_TRUE: s_d.true_cmos = 1'b1;
                `ODCP_PAD_CMOS_COMP: s_d.comp_cmos = 1'b1;
                `ODCP_PAD_CMOS_BOTH:
                begin
                    s_d.true_cmos = 1'b1;
                    s_d.comp_cmos = 1'b1;
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign cfg_rdata = s_q.rdata;
    assign true_pad_drive = s_q.true_pad;
    assign comp_pad_drive = s_q.comp_pad;
    assign fine_step = s_q.fine_step;
    assign drive_strength = s_q.strength;
    assign supply_level_code = s_q.supply_sel;
    assign driver_standard_select = s_q.driver_sel;
    assign true_cmos_en = s_q.true_cmos;
    assign comp_cmos_en = s_q.comp_cmos;
    assign diff_en = s_q.diff_en;
    assign pullup_en = s_q.pullup_en;
    assign pulldown_en = s_q.pulldown_en;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_div_low_byte: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && cfg_wr && cfg_addr == `ODCP_ADDR_DIV_LOW)
        |=> output_divide_ratio[7:0] == $past(cfg_wdata))
        else $error("divider low byte not taken from its register");

    a_div_top_bits: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && cfg_wr && cfg_addr == `ODCP_ADDR_SUPPLY)
        |=> output_divide_ratio[29:28] == $past(cfg_wdata[7:6]))
        else $error("divider bits 29:28 not taken from supply register");

    a_phase_same: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_q.phase_ctl[7:6] == 2'h1) |=> true_pad_drive == comp_pad_drive)
        else $error("phase code 01 did not drive both pads alike");

    a_phase_split: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_q.phase_ctl[7:6] == 2'h0) |=> true_pad_drive != comp_pad_drive)
        else $error("phase code 00 did not drive opposite phases");

    a_fine_limit: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && fine_code == 3'h7) |=> fine_step == 3'h4)
        else $error("fine step code not clamped at four");

    a_fine_plain: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !s_q.pad_ctl[4]) |=> fine_step == {1'b0, $past(s_q.delay_ctl[7:6])})
        else $error("fine step differs from its two-bit field");

    a_supply_3v3: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_q.supply_ctl[4:3] == 2'h2) |=> supply_level_code == 3'h4)
        else $error("supply code 10 not decoded as 3.3 V");

    a_driver_boost: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_q.supply_ctl[2:0] == 3'h4) |=> driver_standard_select == 6'h10)
        else $error("driver code 100 not decoded as boosted");

    a_pad_both: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_q.pad_ctl[3:0] == 4'hc) |=> true_cmos_en && comp_cmos_en && !diff_en)
        else $error("pad code 1100 did not enable both CMOS pads");

    a_pad_diff: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_q.pad_ctl[3:0] == 4'h0)
        |=> diff_en && !pullup_en && !pulldown_en && !true_cmos_en)
        else $error("pad code 0000 not external differential");

    a_div_high_time: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && output_divide_ratio == 30'h4 && !s_q.div_clk) ##1
        (ce && s_q.div_clk && output_divide_ratio == 30'h4) ##1 ce
        |-> s_q.div_clk ##0 (ce [*1] ##1 !s_q.div_clk))
        else $error("divide by four did not stay high two cycles");

    a_read_back: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && cfg_wr && cfg_addr == `ODCP_ADDR_DIV_MID) ##1
        (ce && cfg_rd && !cfg_wr && cfg_addr == `ODCP_ADDR_DIV_MID)
        |=> cfg_rdata == $past(cfg_wdata, 2))
        else $error("written divider byte not read back");

    a_phase_comp: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && phase_sel == 2'h2)
        |=> (true_pad_drive == !$past(delayed_clk))
            && (comp_pad_drive == !$past(delayed_clk)))
        else $error("phase code 10 did not put the complement on both pads");

    a_phase_swap: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && phase_sel == 2'h3)
        |=> (true_pad_drive == !$past(delayed_clk))
            && (comp_pad_drive == $past(delayed_clk)))
        else $error("phase code 11 did not swap the two phases");

    a_pad_pullup: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_q.pad_ctl[3:0] == 4'h2) |=> diff_en && pullup_en && !pulldown_en)
        else $error("pad code 0010 not differential with pull-up");

    a_pad_comp_only: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_q.pad_ctl[3:0] == 4'h8) |=> comp_cmos_en && !true_cmos_en && !diff_en)
        else $error("pad code 1000 did not drive the negative pad alone");

    a_ratio_park: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && output_divide_ratio < `ODCP_RATIO_MIN) |=> !s_q.div_clk)
        else $error("divided clock not parked low for ratio below two");

    a_supply_1v8: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_q.supply_ctl[4:3] == 2'h0) |=> supply_level_code == 3'h1)
        else $error("supply code 00 not decoded as 1.8 V");
endmodule // odcp_output_page

// >>> rtl/odcp_pkg.sv
// Types shared by the output divider page modules
package odcp_pkg;
    typedef logic [7:0] odcp_byte_t;
    typedef logic [29:0] odcp_ratio_t;
    typedef logic [5:0] odcp_coarse_t;

    typedef struct packed {
        logic [62:0] line;
        logic out;
    } odcp_dly_s;

    typedef struct packed {
        odcp_byte_t div_high;
        odcp_byte_t div_mid;
        odcp_byte_t div_low;
        odcp_byte_t phase_ctl;
        odcp_byte_t delay_ctl;
        odcp_byte_t supply_ctl;
        odcp_byte_t pad_ctl;
        odcp_byte_t rdata;
        odcp_ratio_t cnt;
        logic div_clk;
        logic true_pad;
        logic comp_pad;
        logic [2:0] fine_step;
        logic [2:0] strength;
        logic [2:0] supply_sel;
        logic [5:0] driver_sel;
        logic true_cmos;
        logic comp_cmos;
        logic diff_en;
        logic pullup_en;
        logic pulldown_en;
    } odcp_state_s;
endpackage
